/* hdl/settle_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module settle_timer #(
	parameter int CYCLES = 100
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic enable_i,
	output logic done_o
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LAST = CW'(CYCLES);
	logic [CW-1:0] count;

	initial begin
		if (CYCLES < 1) begin
			$error("settle_timer needs at least one cycle");
		end
	end

	// Counts up to CYCLES while enabled and holds there, restarts when disabled
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count <= '0;
		end else if (!enable_i) begin
			count <= '0;
		end else if (count != LAST) begin
			count <= count + 1'b1;
		end
	end

	// Done is a flop so readback stays glitch free
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			done_o <= 1'b0;
		end else begin
			done_o <= enable_i && (count == LAST);
		end
	end
endmodule
`default_nettype wire

/* hdl/voltage_reference_control.sv */
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Ladder current flows only while ladder enable is set.
// - Thirty-two ladder levels chosen by five-bit level code.
// - Enabled output is negative source plus span times code over 32.
// - Ladder voltage reaches the pin only while pin enable set.
// - Pin output overrides digital driver and input detector.
// - Digital read of reference pin returns zero while routed.
// - Fixed reference runs only while its enable bit is set.
// - Gain select gives x1, x2, x4; code zero reserved.
// - Read-only stable flag rises after fixed reference settles.
// - Reset disables both references, pin route, clears level code.
// - Waking from sleep leaves register contents unchanged.
// - Unimplemented register bits read as zero.
// - Level code is right-justified in its register.
// - Ladder ignores all comparator settings.
module voltage_reference_control #(
	parameter int SETTLE = vref_pkg::SETTLE_CYCLES
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic [1:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic pin_digital_i,
	input wire logic pin_port_out_i,
	input wire logic pin_port_oe_i,
	input wire logic wake_i,
	output logic pin_digital_o,
	output logic pin_out_o,
	output logic pin_oe_o,
	output logic pin_input_detect_o,
	output logic ladder_enable_o,
	output logic low_power_source_select_o,
	output logic ladder_pin_output_enable_o,
	output logic [1:0] positive_source_select_o,
	output logic negative_source_select_o,
	output logic [vref_pkg::LEVEL_BITS-1:0] ladder_level_code_o,
	output logic [1:0] ladder_tap_select_o,
	output logic fixed_ref_enable_o,
	output logic [1:0] fixed_ref_gain_select_o,
	output logic [2:0] fixed_ref_gain_o
);
	import vref_pkg::*;

	// Tap select codes for the analog mux
	localparam logic [1:0] TAP_OFF = 2'h0;
	localparam logic [1:0] TAP_DIVIDER = 2'h1;
	localparam logic [1:0] TAP_POS = 2'h2;
	localparam logic [1:0] TAP_NEG = 2'h3;
	localparam logic [LEVEL_BITS-1:0] CODE_MAX = '1;
	localparam logic [LEVEL_BITS-1:0] CODE_MIN = '0;

	initial begin
		if (LEVEL_BITS < 1 || LEVEL_BITS > 5) begin
			$error("level code must fit bits 4 to 0");
		end
		if (SETTLE < 1) begin
			$error("settle count must be at least one");
		end
	end

	// Stored register state
	logic fixed_ref_enable;
	logic [1:0] fixed_ref_gain_select;
	logic ladder_enable;
	logic low_power_source_select;
	logic ladder_pin_output_enable;
	logic [1:0] positive_source_select;
	logic negative_source_select;
	logic [LEVEL_BITS-1:0] ladder_level_code;
	logic fixed_ref_stable;
	logic pin_sync1, pin_sync2;

	// Decode shared by write and read paths
	function automatic logic hit(input logic [1:0] a, input logic [1:0] r);
		hit = (a == r);
	endfunction

	// Gain multiplier from the select code, reserved gives none
	function automatic logic [2:0] gain_of(input logic [1:0] g);
		case (g)
			2'h1: gain_of = 3'h1;
			2'h2: gain_of = 3'h2;
			2'h3: gain_of = 3'h4;
			default: gain_of = 3'h0;
		endcase
	endfunction

	// Readable bits of each register, everything else reads zero
	function automatic logic [7:0] read_mask(input logic [1:0] a);
		case (a)
			ADDR_FIXED_REF_CONTROL: begin
				read_mask = FIXED_REF_WMASK | (8'h01 << FIXED_REF_STABLE_BIT);
			end
			ADDR_LADDER_CONTROL: read_mask = LADDER_CTRL_WMASK;
			ADDR_LADDER_LEVEL: read_mask = LADDER_LEVEL_WMASK;
			default: read_mask = 8'h00;
		endcase
	endfunction

	// Fixed reference control, stable bit is not writable
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fixed_ref_enable <= 1'b0;
			fixed_ref_gain_select <= GAIN_RESET;
		end else if (wr_i && hit(addr_i, ADDR_FIXED_REF_CONTROL)) begin
			fixed_ref_enable <= wdata_i[FIXED_REF_ENABLE_BIT];
			fixed_ref_gain_select <= wdata_i[FIXED_REF_GAIN_HI:FIXED_REF_GAIN_LO];
		end
	end

	// Ladder control; wake has no effect on any register
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ladder_enable <= 1'b0;
			low_power_source_select <= 1'b0;
			ladder_pin_output_enable <= 1'b0;
			positive_source_select <= POS_SRC_RESET;
			negative_source_select <= NEG_SRC_RESET;
		end else if (wr_i && hit(addr_i, ADDR_LADDER_CONTROL)) begin
			ladder_enable <= wdata_i[LADDER_ENABLE_BIT];
			low_power_source_select <= wdata_i[LOW_POWER_SRC_BIT];
			ladder_pin_output_enable <= wdata_i[LADDER_PIN_OE_BIT];
			positive_source_select <= wdata_i[POS_SRC_HI:POS_SRC_LO];
			negative_source_select <= wdata_i[NEG_SRC_BIT];
		end
	end

	// Level code sits in the low bits of its register
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ladder_level_code <= '0;
		end else if (wr_i && hit(addr_i, ADDR_LADDER_LEVEL)) begin
			ladder_level_code <= wdata_i[LEVEL_BITS-1:0];
		end
	end

	// Stable flag only after a full settling run while enabled
	settle_timer #(
		.CYCLES(SETTLE)
	) u_settle (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.enable_i(fixed_ref_enable),
		.done_o(fixed_ref_stable)
	);

	// Read data, one cycle after the strobe, zero otherwise
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			rdata_o <= 8'h00;
			if (hit(addr_i, ADDR_FIXED_REF_CONTROL)) begin
				rdata_o[FIXED_REF_ENABLE_BIT] <= fixed_ref_enable;
				rdata_o[FIXED_REF_STABLE_BIT] <= fixed_ref_stable;
				rdata_o[FIXED_REF_GAIN_HI:FIXED_REF_GAIN_LO] <=
					fixed_ref_gain_select;
			end else if (hit(addr_i, ADDR_LADDER_CONTROL)) begin
				rdata_o[LADDER_ENABLE_BIT] <= ladder_enable;
				rdata_o[LOW_POWER_SRC_BIT] <= low_power_source_select;
				rdata_o[LADDER_PIN_OE_BIT] <= ladder_pin_output_enable;
				rdata_o[POS_SRC_HI:POS_SRC_LO] <= positive_source_select;
				rdata_o[NEG_SRC_BIT] <= negative_source_select;
			end else if (hit(addr_i, ADDR_LADDER_LEVEL)) begin
				rdata_o[LEVEL_BITS-1:0] <= ladder_level_code;
			end
		end else begin
			rdata_o <= 8'h00;
		end
	end

	// Pin synchroniser for the digital read path
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_sync1 <= 1'b0;
			pin_sync2 <= 1'b0;
		end else begin
			pin_sync1 <= pin_digital_i;
			pin_sync2 <= pin_sync1;
		end
	end

	// Pin ownership: reference output takes over the pin
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_out_o <= 1'b0;
			pin_oe_o <= 1'b0;
			pin_input_detect_o <= 1'b1;
			pin_digital_o <= 1'b0;
		end else begin
			pin_out_o <= pin_port_out_i;
			pin_oe_o <= pin_port_oe_i && !ladder_pin_output_enable;
			pin_input_detect_o <= !ladder_pin_output_enable;
			pin_digital_o <= pin_sync2 && !ladder_pin_output_enable;
		end
	end

	// Ladder tap: divider when on, rails at the two end codes in low-power off state, otherwise off
	logic [1:0] next_tap;
	always_comb begin
		next_tap = TAP_OFF;
		if (ladder_enable) begin
			next_tap = TAP_DIVIDER;
		end else if (low_power_source_select) begin
			if (ladder_level_code == CODE_MAX) begin
				next_tap = TAP_POS;
			end else if (ladder_level_code == CODE_MIN) begin
				next_tap = TAP_NEG;
			end
		end
	end

	// Analog controls straight from stored bits, no comparator input
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ladder_enable_o <= 1'b0;
			low_power_source_select_o <= 1'b0;
			ladder_pin_output_enable_o <= 1'b0;
			positive_source_select_o <= POS_SRC_RESET;
			negative_source_select_o <= NEG_SRC_RESET;
			ladder_level_code_o <= '0;
			ladder_tap_select_o <= TAP_OFF;
		end else begin
			ladder_enable_o <= ladder_enable;
			low_power_source_select_o <= low_power_source_select;
			ladder_pin_output_enable_o <= ladder_pin_output_enable;
			positive_source_select_o <= positive_source_select;
			negative_source_select_o <= negative_source_select;
			ladder_level_code_o <= ladder_level_code;
			ladder_tap_select_o <= next_tap;
		end
	end

	// Fixed reference outputs; reserved gain yields zero gain
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fixed_ref_enable_o <= 1'b0;
			fixed_ref_gain_select_o <= GAIN_RESET;
			fixed_ref_gain_o <= 3'h0;
		end else begin
			fixed_ref_enable_o <= fixed_ref_enable;
			fixed_ref_gain_select_o <= fixed_ref_gain_select;
			fixed_ref_gain_o <= fixed_ref_enable ?
				gain_of(fixed_ref_gain_select) : 3'h0;
		end
	end

	// Checks
	sequence write_ladder_s;
		wr_i && addr_i == ADDR_LADDER_CONTROL;
	endsequence

	ladder_enable_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		write_ladder_s |=> ##1
		ladder_enable_o == $past(wdata_i[LADDER_ENABLE_BIT], 2))
		else $error("ladder enable did not follow write");

	level_code_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		wr_i && addr_i == ADDR_LADDER_LEVEL |=> ##1
		ladder_level_code_o == $past(wdata_i[LEVEL_BITS-1:0], 2))
		else $error("level code did not follow write");

	tap_divider_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ladder_enable |=> ladder_tap_select_o == TAP_DIVIDER)
		else $error("tap not divider while enabled");

	tap_rail_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		!ladder_enable && low_power_source_select && ladder_level_code == CODE_MAX
		|=> ladder_tap_select_o == TAP_POS)
		else $error("low power top code not positive");

	pin_read_zero_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		ladder_pin_output_enable [*2] |-> pin_digital_o == 1'b0 && !pin_oe_o)
		else $error("pin not zero while routed");

	fixed_gain_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		fixed_ref_enable && fixed_ref_gain_select == 2'h3
		|=> fixed_ref_gain_o == 3'h4)
		else $error("gain four not produced");

	stable_off_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		!fixed_ref_enable |=> !fixed_ref_stable)
		else $error("stable while disabled");

	unimpl_zero_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		rd_i |=> (rdata_o & ~read_mask($past(addr_i))) == 8'h00)
		else $error("unimplemented bits not zero");

	wake_hold_a: assert property (@(posedge mclk_i) disable iff (!arst_n_i)
		wake_i && !wr_i |=> $stable(ladder_level_code))
		else $error("wake changed registers");
endmodule
`default_nettype wire

/* pkg/vref_pkg.sv */
package vref_pkg;
	// Register indices on the plain port
	localparam logic [1:0] ADDR_FIXED_REF_CONTROL = 2'h0;
	localparam logic [1:0] ADDR_LADDER_CONTROL = 2'h1;
	localparam logic [1:0] ADDR_LADDER_LEVEL = 2'h2;
	// fixed_ref_control fields
	localparam int FIXED_REF_ENABLE_BIT = 7;
	localparam int FIXED_REF_STABLE_BIT = 6;
	localparam int FIXED_REF_GAIN_HI = 5;
	localparam int FIXED_REF_GAIN_LO = 4;
	// ladder_control fields
	localparam int LADDER_ENABLE_BIT = 7;
	localparam int LOW_POWER_SRC_BIT = 6;
	localparam int LADDER_PIN_OE_BIT = 5;
	localparam int POS_SRC_HI = 3;
	localparam int POS_SRC_LO = 2;
	localparam int NEG_SRC_BIT = 0;
	// Level code width
	localparam int LEVEL_BITS = 5;
	// Reset values
	localparam logic [1:0] GAIN_RESET = 2'h1;
	localparam logic [1:0] POS_SRC_RESET = 2'h0;
	localparam logic NEG_SRC_RESET = 1'b0;
	// Writable masks, unimplemented bits read zero
	localparam logic [7:0] FIXED_REF_WMASK = 8'hB0;
	localparam logic [7:0] LADDER_CTRL_WMASK = 8'hED;
	localparam logic [7:0] LADDER_LEVEL_WMASK = 8'h1F;
	// Source and gain encodings
	localparam logic [1:0] POS_SRC_SUPPLY = 2'h0;
	localparam logic [1:0] POS_SRC_EXT = 2'h1;
	localparam logic [1:0] POS_SRC_FIXED = 2'h2;
	localparam logic [1:0] POS_SRC_RESERVED = 2'h3;
	localparam logic [1:0] GAIN_RESERVED = 2'h0;
	// Settling time of the fixed reference
	localparam int SETTLE_NS = 1000;
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* testbench/pin_far_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Far side of the reference pin: board level plus the analog reference
module pin_far_model (
	input wire logic drive_i,
	input wire logic drive_en_i,
	input wire logic routed_i,
	input wire logic board_i,
	output logic level_o
);
	// Routed analog level sits near mid rail, seen high by a live input
	// stage, so a forced zero in the device can't pass by luck
	always_comb begin
		if (drive_en_i) begin
			level_o = drive_i;
		end else if (routed_i) begin
			level_o = 1'b1;
		end else begin
			level_o = board_i;
		end
	end
endmodule
`default_nettype wire

/* testbench/voltage_reference_control_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
	err_count++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module voltage_reference_control_tb;
	import vref_pkg::*;
	localparam int SET = 8;
	logic mclk_i, arst_n_i, wr_i, rd_i, wake_i, board;
	logic pin_port_out_i, pin_port_oe_i, pin_digital_i;
	logic [1:0] addr_i, positive_source_select_o, ladder_tap_select_o;
	logic [1:0] fixed_ref_gain_select_o;
	logic [7:0] wdata_i, rdata_o;
	logic pin_digital_o, pin_out_o, pin_oe_o, pin_input_detect_o;
	logic ladder_enable_o, low_power_source_select_o;
	logic ladder_pin_output_enable_o, negative_source_select_o;
	logic fixed_ref_enable_o;
	logic [LEVEL_BITS-1:0] ladder_level_code_o;
	logic [2:0] fixed_ref_gain_o;
	int err_count = 0;
	int comparisons = 0;
	voltage_reference_control #(.SETTLE(SET)) dut_u (.*);
	pin_far_model far_u (.drive_i(pin_out_o), .drive_en_i(pin_oe_o),
		.routed_i(ladder_pin_output_enable_o), .board_i(board),
		.level_o(pin_digital_i));
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	// Register port master, outputs settled two edges after the strobe
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge mclk_i);
		wr_i <= 1'b0;
		@(posedge mclk_i);
		#1;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] e);
		@(posedge mclk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge mclk_i);
		rd_i <= 1'b0;
		#1;
		`CHK("rdata", e, rdata_o)
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic t_reset;
		rd(ADDR_FIXED_REF_CONTROL, 8'h10);
		rd(ADDR_LADDER_CONTROL, 8'h00);
		rd(ADDR_LADDER_LEVEL, 8'h00);
		`CHK("ladder_en", 1'b0, ladder_enable_o)
		`CHK("fixed_en", 1'b0, fixed_ref_enable_o)
		`CHK("detect", 1'b1, pin_input_detect_o)
		$display("test reset done");
	endtask
	task automatic t_ladder;
		wr(ADDR_LADDER_CONTROL, 8'hFF);
		`CHK("ladder_en", 1'b1, ladder_enable_o)
		`CHK("tap", 2'h1, ladder_tap_select_o)
		`CHK("pin_route", 1'b1, ladder_pin_output_enable_o)
		`CHK("neg_src", 1'b1, negative_source_select_o)
		`CHK("low_pwr", 1'b1, low_power_source_select_o)
		`CHK("pin_oe", 1'b0, pin_oe_o)
		`CHK("detect", 1'b0, pin_input_detect_o)
		wait_cyc(4);
		`CHK("pin_rd", 1'b0, pin_digital_o)
		rd(ADDR_LADDER_CONTROL, 8'hED);
		// Every positive source code, ladder off
		for (int p = 0; p < 4; p++) begin
			wr(ADDR_LADDER_CONTROL, {4'h0, 2'(p), 2'h0});
			`CHK("pos_src", 2'(p), positive_source_select_o)
			`CHK("ladder_en", 1'b0, ladder_enable_o)
		end
		$display("test ladder done");
	endtask
	task automatic t_level;
		wr(ADDR_LADDER_LEVEL, 8'hFF);
		rd(ADDR_LADDER_LEVEL, 8'h1F);
		`CHK("code", 5'h1F, ladder_level_code_o)
		wr(ADDR_LADDER_CONTROL, 8'h40);
		`CHK("tap", 2'h2, ladder_tap_select_o)
		wr(ADDR_LADDER_LEVEL, 8'h00);
		`CHK("tap", 2'h3, ladder_tap_select_o)
		wr(ADDR_LADDER_LEVEL, 8'h05);
		`CHK("tap", 2'h0, ladder_tap_select_o)
		`CHK("code", 5'h05, ladder_level_code_o)
		$display("test level done");
	endtask
	task automatic t_pin;
		pin_port_out_i <= 1'b1;
		pin_port_oe_i <= 1'b1;
		board <= 1'b0;
		wait_cyc(5);
		`CHK("pin_oe", 1'b1, pin_oe_o)
		`CHK("pin_out", 1'b1, pin_out_o)
		`CHK("detect", 1'b1, pin_input_detect_o)
		pin_port_oe_i <= 1'b0;
		board <= 1'b1;
		wait_cyc(5);
		`CHK("pin_rd", 1'b1, pin_digital_o)
		$display("test pin done");
	endtask
	task automatic t_fixed;
		wr(ADDR_FIXED_REF_CONTROL, 8'hF0);
		rd(ADDR_FIXED_REF_CONTROL, 8'hB0);
		// Software side polls only after the settling span
		wait_cyc(SET + 4);
		rd(ADDR_FIXED_REF_CONTROL, 8'hF0);
		`CHK("fixed_en", 1'b1, fixed_ref_enable_o)
		for (int g = 0; g < 4; g++) begin
			wr(ADDR_FIXED_REF_CONTROL, {2'h2, 2'(g), 4'h0});
			`CHK("gain", (g == 0) ? 3'h0 : 3'(1 << (g - 1)), fixed_ref_gain_o)
			`CHK("gain_sel", 2'(g), fixed_ref_gain_select_o)
		end
		wr(ADDR_FIXED_REF_CONTROL, 8'h30);
		wait_cyc(2);
		rd(ADDR_FIXED_REF_CONTROL, 8'h30);
		`CHK("fixed_en", 1'b0, fixed_ref_enable_o)
		`CHK("gain", 3'h0, fixed_ref_gain_o)
		$display("test fixed done");
	endtask
	task automatic t_misc;
		wake_i <= 1'b1;
		wr(2'h3, 8'hFF);
		rd(2'h3, 8'h00);
		rd(ADDR_LADDER_LEVEL, 8'h05);
		rd(ADDR_LADDER_CONTROL, 8'h40);
		wake_i <= 1'b0;
		wait_cyc(1);
		arst_n_i = 1'b0;
		wait_cyc(2);
		arst_n_i = 1'b1;
		rd(ADDR_LADDER_LEVEL, 8'h00);
		`CHK("low_pwr", 1'b0, low_power_source_select_o)
		$display("test misc done");
	endtask
	initial begin
		{arst_n_i, wr_i, rd_i, wake_i, board} = '0;
		{pin_port_out_i, pin_port_oe_i, addr_i, wdata_i} = '0;
		repeat (10) @(posedge mclk_i);
		#1;
		arst_n_i = 1'b1;
		t_reset();
		t_ladder();
		t_level();
		t_pin();
		t_fixed();
		t_misc();
		end_sim();
	end
	// Whole run takes just over a hundred cycles
	initial begin
		repeat (3000) @(posedge mclk_i);
		err_count++;
		end_sim();
	end
endmodule
`default_nettype wire
